/* hdl/epmb_block.sv */
// embedded block: product-term macrocells or synchronous RAM, APB configured
module epmb_block (
	input  wire logic              ref_clk,  // 100 MHz clock
	input  wire logic              rstn,     // async reset, active low
	input  wire logic              psel,     // apb select
	input  wire logic              penable,  // apb enable
	input  wire logic              pwrite,   // apb direction
	input  wire logic [11:0]       paddr,    // apb byte address
	input  wire logic [31:0]       pwdata,   // apb write data
	output logic      [31:0]       prdata,   // apb read data
	output logic                   pready,   // apb ready, zero wait
	output logic                   pslverr,  // apb error on unmapped
	input  epmb_pkg::epmb_fab_t    fab,      // raw fabric signals
	output logic      [15:0]       blk_out,  // block outputs
	output logic      [9:0]        local_out,// local routing outputs
	output logic      [15:0]       col_data, // column line data
	output logic                   col_oe    // column line enable
);
	// fabric inputs cross in through two flops
	epmb_pkg::epmb_fab_t fab_m;
	epmb_pkg::epmb_fab_t fab_s;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fab_m <= '0;
			fab_s <= '0;
		end else begin
			fab_m <= fab;
			fab_s <= fab_m;
		end
	end

	// configuration storage
	logic [31:0] ctrl;
	logic [31:0] mc_cfg [epmb_pkg::NUM_MC];
	logic [31:0] pt_cfg [epmb_pkg::PT_WORDS];

	// apb decode; every mapped register answers at once
	wire         aligned  = (paddr[1:0] == 2'h0);
	wire         hit_ctrl = (paddr == epmb_pkg::OFF_CTRL);
	wire         hit_st   = (paddr == epmb_pkg::OFF_STATUS);
	wire         hit_mc   = aligned && paddr >= epmb_pkg::OFF_MC_BASE
				&& paddr < epmb_pkg::OFF_MC_END;
	wire         hit_pt   = aligned && paddr >= epmb_pkg::OFF_PT_BASE
				&& paddr < epmb_pkg::OFF_PT_END;
	wire         mapped   = hit_ctrl || hit_st || hit_mc || hit_pt;
	wire [11:0]  pt_off   = paddr - epmb_pkg::OFF_PT_BASE;
	wire [6:0]   pt_idx   = pt_off[8:2];
	wire [3:0]   mc_idx   = paddr[5:2];
	wire         acc      = psel && penable;
	wire         apb_wr   = acc && pwrite && mapped;
	wire [31:0]  status;
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata  = (!psel || pwrite || !mapped) ? 32'h0000_0000 :
			hit_ctrl ? ctrl : hit_st ? status :
			hit_mc ? mc_cfg[mc_idx] : pt_cfg[pt_idx];

	// register writes; status is read only
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= epmb_pkg::CTRL_RST;
			for (int i = 0; i < epmb_pkg::NUM_MC; i++) begin
				mc_cfg[i] <= epmb_pkg::MC_RST;
			end
			for (int i = 0; i < epmb_pkg::PT_WORDS; i++) begin
				pt_cfg[i] <= epmb_pkg::PT_RST;
			end
		end else if (apb_wr) begin
			if (hit_ctrl) begin
				ctrl <= pwdata;
			end
			if (hit_mc) begin
				mc_cfg[mc_idx] <= pwdata;
			end
			if (hit_pt) begin
				pt_cfg[pt_idx] <= pwdata;
			end
		end
	end

	// mode fields
	wire       role_mem = ctrl[epmb_pkg::CTL_ROLE];
	wire [2:0] asp_raw  = ctrl[epmb_pkg::CTL_ASPECT +: 3];
	wire [2:0] asp      = (asp_raw > 3'h4) ? 3'h4 : asp_raw;
	wire [1:0] cmode    = ctrl[epmb_pkg::CTL_CMODE +: 2];
	wire       pg_en    = ctrl[epmb_pkg::CTL_PGEN];
	wire [1:0] pg_id    = ctrl[epmb_pkg::CTL_PGID +: 2];

	// block clock edges from the sampled clocks, gated by enables
	logic [1:0] clk_d;
	wire  [1:0] rise = fab_s.blk_clk & ~clk_d;
	wire  [1:0] fall = ~fab_s.blk_clk & clk_d;
	wire  [1:0] edg  = (ctrl[epmb_pkg::CTL_FALL +: 2] & fall)
			| (~ctrl[epmb_pkg::CTL_FALL +: 2] & rise);
	wire  [1:0] ev   = edg & fab_s.blk_clk_en;
	wire  [1:0] clr  = fab_s.blk_clr ^ ctrl[epmb_pkg::CTL_CLRINV +: 2];
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			clk_d <= 2'h0;
		end else begin
			clk_d <= fab_s.blk_clk;
		end
	end

	// product terms over 32 routing inputs plus 9 feedback lines
	logic [8:0]  fb_q;
	wire  [40:0] lits = {fb_q, fab_s.fab_in};
	wire  [31:0] pterm;
	for (genvar k = 0; k < epmb_pkg::NUM_PT; k++) begin : g_pt
		wire [40:0] tm = {pt_cfg[3*k+2][8:0], pt_cfg[3*k]};
		wire [40:0] cm = {pt_cfg[3*k+2][24:16], pt_cfg[3*k+1]};
		assign pterm[k] = &(~tm | lits) && &(~cm | ~lits);
	end

	// macrocells: select matrix, expander chain, register
	wire  [15:0] mc_d;
	wire  [15:0] mc_sum;
	wire  [15:0] mc_nxt;
	wire  [15:0] mc_clr;
	wire  [15:0] mc_tick;
	wire  [15:0] exp_out;
	wire  [15:0] mc_out;
	logic [15:0] mc_q;
	for (genvar m = 0; m < epmb_pkg::NUM_MC; m++) begin : g_mc
		wire [31:0] cf  = mc_cfg[m];
		wire [1:0]  rt  = cf[epmb_pkg::MC_RTYPE +: 2];
		wire        two = (rt == epmb_pkg::EPMB_RT_JK)
				|| (rt == epmb_pkg::EPMB_RT_SR);
		wire        t0  = pterm[2*m];
		wire        t1  = pterm[2*m+1] ^ cf[epmb_pkg::MC_INV1];
		wire        l0  = cf[epmb_pkg::MC_LEND0];
		wire        l1  = cf[epmb_pkg::MC_LEND1];
		wire        cin = (m == 0) ? 1'b0 : exp_out[(m == 0) ? 0 : m-1];
		wire        tk  = cf[epmb_pkg::MC_CHAIN] && cin;
		wire [1:0]  cs  = cf[epmb_pkg::MC_CLR +: 2];
		// lent terms plus the chain forwarded to the next macrocell
		assign exp_out[m] = (l0 && t0) || (l1 && t1) || tk;
		// own unlent terms (the second only for d and t types) plus borrowed expanders
		assign mc_sum[m] = (t0 && !l0) || (t1 && !l1 && !two) || tk;
		assign mc_d[m]   = mc_sum[m] ^ cf[epmb_pkg::MC_XOR];
		assign mc_tick[m] = ev[cf[epmb_pkg::MC_CSEL]];
		assign mc_clr[m]  = (cs == 2'h1 && clr[0]) || (cs == 2'h2 && clr[1]);
		// second input of jk/sr comes from the own second term
		assign mc_nxt[m] = (rt == epmb_pkg::EPMB_RT_T)  ? (mc_q[m] ^ mc_d[m]) :
				(rt == epmb_pkg::EPMB_RT_JK) ? ((mc_d[m] && !mc_q[m])
					|| (!t1 && mc_q[m])) :
				(rt == epmb_pkg::EPMB_RT_SR) ? (mc_d[m] || (!t1 && mc_q[m])) :
				mc_d[m];
		assign mc_out[m] = cf[epmb_pkg::MC_BYP] ? mc_d[m] : mc_q[m];
	end

	// macrocell registers; clear is sampled, so it acts within a cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mc_q <= 16'h0000;
			fb_q <= 9'h000;
		end else begin
			for (int i = 0; i < epmb_pkg::NUM_MC; i++) begin
				if (mc_clr[i]) begin
					mc_q[i] <= 1'b0;
				end else if (mc_tick[i]) begin
					mc_q[i] <= mc_nxt[i];
				end
			end
			// flop in the feedback path breaks combinational loops
			fb_q <= mc_out[8:0];
		end
	end

	// memory geometry per aspect ratio
	function automatic logic [10:0] epmb_bitpos(input logic [10:0] a, input logic [2:0] k);
		case (k)
			3'h0: epmb_bitpos = {a[6:0], 4'h0};
			3'h1: epmb_bitpos = {a[7:0], 3'h0};
			3'h2: epmb_bitpos = {a[8:0], 2'h0};
			3'h3: epmb_bitpos = {a[9:0], 1'b0};
			default: epmb_bitpos = a;
		endcase
	endfunction
	function automatic logic [15:0] epmb_lane(input logic [2:0] k);
		case (k)
			3'h0: epmb_lane = 16'hffff;
			3'h1: epmb_lane = 16'h00ff;
			3'h2: epmb_lane = 16'h000f;
			3'h3: epmb_lane = 16'h0003;
			default: epmb_lane = 16'h0001;
		endcase
	endfunction

	// clock roles of the memory registers
	wire wev = ev[0];
	wire rev = (cmode == epmb_pkg::EPMB_CM_RW) ? ev[1] : ev[0];
	wire oev = (cmode == epmb_pkg::EPMB_CM_SINGLE) ? ev[0] : ev[1];

	logic [15:0] mem [epmb_pkg::MEM_ROWS];
	logic [15:0] wd_q;
	logic [12:0] wa_q;
	logic        we_q;
	logic [1:0]  rpg_q;
	logic [15:0] rd_word;
	logic [15:0] dout_q;
	wire  [15:0] lmask  = epmb_lane(asp);
	wire  [10:0] wbit   = epmb_bitpos(wa_q[10:0], asp);
	wire  [10:0] rbit   = epmb_bitpos(fab_s.mem_raddr[10:0], asp);
	wire  [15:0] rrow   = mem[rbit[10:4]];
	wire         wr_hit = !pg_en || (wa_q[12:11] == pg_id);
	wire         wr_go  = we_q && wr_hit && role_mem;

	// input side registers; pending write is the self-timed strobe
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wd_q <= 16'h0000;
			wa_q <= 13'h0000;
			we_q <= 1'b0;
		end else if (clr[0]) begin
			wd_q <= 16'h0000;
			wa_q <= 13'h0000;
			we_q <= 1'b0;
		end else if (wev) begin
			wd_q <= fab_s.mem_wdata;
			wa_q <= fab_s.mem_waddr;
			we_q <= fab_s.mem_we && role_mem;
		end else if (we_q) begin
			we_q <= 1'b0;
		end
	end

	// array holds no reset, so clears leave contents intact
	always_ff @(posedge ref_clk) begin
		if (wr_go) begin
			mem[wbit[10:4]] <= (mem[wbit[10:4]] & ~(lmask << wbit[3:0]))
				| ((wd_q & lmask) << wbit[3:0]);
		end
	end

	// read side and output registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_word <= 16'h0000;
			rpg_q   <= 2'h0;
			dout_q  <= 16'h0000;
		end else if (clr[1]) begin
			rd_word <= 16'h0000;
			rpg_q   <= 2'h0;
			dout_q  <= 16'h0000;
		end else begin
			// array read sees the word before a same-cycle write
			if (rev && fab_s.read_strobe) begin
				rd_word <= (rrow >> rbit[3:0]) & lmask;
				rpg_q   <= fab_s.mem_raddr[12:11];
			end
			if (oev) begin
				dout_q <= rd_word;
			end
		end
	end

	// column line: only the block whose page matches drives it
	wire [15:0] mem_out = ctrl[epmb_pkg::CTL_OREG] ? dout_q : rd_word;
	wire        pg_hit  = !pg_en || (rpg_q == pg_id);
	assign col_oe    = role_mem && pg_hit;
	assign col_data  = mem_out;
	assign blk_out   = role_mem ? mem_out : mc_out;
	// two-block true dual port pairs instances outside this module
	assign local_out = {blk_out[8], blk_out[8:0]};
	assign status    = {14'h0000, we_q, col_oe, blk_out};

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	AST_LOCAL_DUP: assert property (local_out[9] == local_out[8] && local_out[8:0] == blk_out[8:0])
		else $error("local outputs not nine distinct plus duplicate");
	AST_ROLE_PT: assert property (!role_mem |-> blk_out == mc_out)
		else $error("product-term outputs not on block outputs");
	AST_BYPASS: assert property (mc_cfg[0][epmb_pkg::MC_BYP] |-> mc_out[0] == mc_d[0])
		else $error("bypassed macrocell not combinational");
	AST_CLKEN: assert property (ev == 2'h0 && mc_clr == 16'h0000 |=> $stable(mc_q))
		else $error("macrocell changed without enabled edge");
	AST_CLR: assert property (clr[0] && mc_cfg[0][epmb_pkg::MC_CLR +: 2] == 2'h1 |=> !mc_q[0])
		else $error("macrocell clear missed");
	AST_WSTB_SET: assert property (wev && fab_s.mem_we && role_mem && !clr[0] |=> we_q)
		else $error("write not captured");
	AST_WSTB_ONE: assert property (we_q && !wev && !clr[0] |=> !we_q)
		else $error("write strobe longer than one cycle");
	AST_PAGE_OFF: assert property (pg_en && rpg_q != pg_id |-> !col_oe)
		else $error("column driven by unselected page");
	AST_RDPIPE: assert property (oev && !clr[1] |=> dout_q == $past(rd_word))
		else $error("output register missed read word");
	AST_EXP_CHAIN: assert property (mc_cfg[1][epmb_pkg::MC_CHAIN] && exp_out[0] |-> mc_sum[1])
		else $error("borrowed expander ignored");
	COV_WRITE: cover property (wr_go ##[1:8] (rev && fab_s.read_strobe));
	COV_CHAIN: cover property (mc_cfg[1][epmb_pkg::MC_CHAIN] && exp_out[0]);
	COV_IO: cover property (cmode == epmb_pkg::EPMB_CM_IO && oev && col_oe);
endmodule

/* hdl/epmb_pkg.sv */
// constants, field layout and carrier types for the embedded block
package epmb_pkg;
	localparam int NUM_IN   = 32;
	localparam int NUM_MC   = 16;
	localparam int NUM_FB   = 9;
	localparam int NUM_PT   = 32;
	localparam int PT_WORDS = 96;
	localparam int MEM_ROWS = 128;
	localparam int MEM_W    = 16;
	localparam int ADDR_W   = 11;
	localparam int PAGE_W   = 2;
	// register byte offsets
	localparam logic [11:0] OFF_CTRL    = 12'h000;
	localparam logic [11:0] OFF_STATUS  = 12'h004;
	localparam logic [11:0] OFF_MC_BASE = 12'h040;
	localparam logic [11:0] OFF_MC_END  = 12'h080;
	localparam logic [11:0] OFF_PT_BASE = 12'h100;
	localparam logic [11:0] OFF_PT_END  = 12'h280;
	// control word fields
	localparam int CTL_ROLE   = 0;
	localparam int CTL_ASPECT = 1;
	localparam int CTL_OREG   = 4;
	localparam int CTL_CMODE  = 5;
	localparam int CTL_FALL   = 7;
	localparam int CTL_CLRINV = 9;
	localparam int CTL_PGEN   = 11;
	localparam int CTL_PGID   = 12;
	// macrocell config fields
	localparam int MC_RTYPE = 0;
	localparam int MC_BYP   = 2;
	localparam int MC_CSEL  = 3;
	localparam int MC_CLR   = 4;
	localparam int MC_INV1  = 6;
	localparam int MC_LEND0 = 7;
	localparam int MC_LEND1 = 8;
	localparam int MC_XOR   = 9;
	localparam int MC_CHAIN = 10;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] MC_RST   = 32'h0000_0000;
	localparam logic [31:0] PT_RST   = 32'h0000_0000;
	typedef enum logic [1:0] {
		EPMB_RT_D  = 2'h0,
		EPMB_RT_T  = 2'h1,
		EPMB_RT_JK = 2'h2,
		EPMB_RT_SR = 2'h3
	} epmb_rtype_t;
	typedef enum logic [1:0] {
		EPMB_CM_SINGLE = 2'h0,
		EPMB_CM_RW     = 2'h1,
		EPMB_CM_IO     = 2'h2
	} epmb_cmode_t;
	typedef struct packed {
		logic [NUM_IN-1:0]        fab_in;
		logic [MEM_W-1:0]         mem_wdata;
		logic [ADDR_W+PAGE_W-1:0] mem_waddr;
		logic [ADDR_W+PAGE_W-1:0] mem_raddr;
		logic                     mem_we;
		logic                     read_strobe;
		logic [1:0]               blk_clk;
		logic [1:0]               blk_clk_en;
		logic [1:0]               blk_clr;
	} epmb_fab_t;
endpackage

/* test/epmb_fabric_model.sv */
// fabric-side model: adjacent logic elements driving the block
module epmb_fabric_model (
	input  wire logic          ref_clk, // system clock
	output epmb_pkg::epmb_fab_t fab     // local routing signals
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle fabric: enables on, block clocks and clears low
	initial begin
		fab = '0;
		fab.blk_clk_en = 2'h3;
	end

	// static levels from neighbouring logic
	task automatic pins(input logic [31:0] v, input logic [1:0] en, input logic [1:0] clr);
		fab.fab_in <= v;
		fab.blk_clk_en <= en;
		fab.blk_clr <= clr;
	endtask

	// one block clock pulse, long enough for the input synchronisers
	task automatic tick(input int c);
		fab.blk_clk[c] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		fab.blk_clk[c] <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	// memory request held through the capturing edge
	task automatic op(input logic we, input logic [12:0] wa, input logic [15:0] wd,
			input logic rs, input logic [12:0] ra, input int c);
		fab.mem_we <= we;
		fab.mem_waddr <= wa;
		fab.mem_wdata <= wd;
		fab.read_strobe <= rs;
		fab.mem_raddr <= ra;
		@(posedge ref_clk);
		tick(c);
		fab.mem_we <= 1'b0;
		// stale data inverted so nothing leans on a held value
		fab.mem_wdata <= ~wd;
		fab.read_strobe <= 1'b0;
	endtask
endmodule

/* test/epmb_block_bench.sv */
// self-checking bench for the embedded block
module epmb_block_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] a_ctl = epmb_pkg::OFF_CTRL;
	localparam logic [11:0] a_mc  = epmb_pkg::OFF_MC_BASE;
	localparam logic [11:0] a_pt  = epmb_pkg::OFF_PT_BASE;
	logic                ref_clk, rstn, psel, penable, pwrite, pready, pslverr, col_oe, err;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata, rd;
	logic [15:0]         blk_out, col_data;
	logic [9:0]          local_out;
	epmb_pkg::epmb_fab_t fab;
	int                  miscompares, check_count;

	epmb_block dut_u (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fab(fab), .blk_out(blk_out), .local_out(local_out),
		.col_data(col_data), .col_oe(col_oe));
	epmb_fabric_model fab_u (.ref_clk(ref_clk), .fab(fab));

	// 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// apb transfer: setup, access held until pready, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) miscompares++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	// memory read through the fabric, then compare the data out
	task automatic mread(input logic [12:0] a, input int c, input logic [15:0] e);
		fab_u.op(1'b0, 13'h0, 16'h0, 1'b1, a, c);
		check(32'(blk_out), 32'(e));
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// watchdog: the tests need well under 2000 cycles
	initial begin
		repeat (8000) @(posedge ref_clk);
		miscompares++;
		complete_run();
	end

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		// registers: reset values, read-back, unmapped address
		rdchk(a_ctl, epmb_pkg::CTRL_RST);
		rdchk(a_mc + 12'h03c, epmb_pkg::MC_RST);
		apb(1'b1, a_mc + 12'h03c, 32'h3);
		rdchk(a_mc + 12'h03c, 32'h3);
		apb(1'b0, 12'h3f0, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		$display("test registers done");
		// mc0 = in0 or (maybe inverted) in1, mc1 copies mc0 by feedback
		apb(1'b1, a_pt, 32'h1);
		apb(1'b1, a_pt + 12'h00c, 32'h2);
		apb(1'b1, a_pt + 12'h020, 32'h1);
		apb(1'b1, a_pt + 12'h02c, 32'h1);
		apb(1'b1, a_mc + 12'h004, 32'h4);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, a_mc, {25'h0, i[2], 6'h04});
			fab_u.pins(32'(i[1:0]), 2'h3, 2'h0);
			repeat (6) @(posedge ref_clk);
			check(32'(blk_out[1:0]), {30'h0, {2{i[0] | (i[1] ^ i[2])}}});
		end
		// registered d on clock 0, enable low holds the state
		apb(1'b1, a_mc, 32'h0);
		fab_u.pins(32'h1, 2'h3, 2'h0);
		fab_u.tick(0);
		check(32'(blk_out[0]), 32'h1);
		fab_u.pins(32'h0, 2'h2, 2'h0);
		fab_u.tick(0);
		check(32'(blk_out[0]), 32'h1);
		// toggle type on clock 1: clock 0 edges ignored
		apb(1'b1, a_mc, 32'h9);
		fab_u.pins(32'h1, 2'h3, 2'h0);
		fab_u.tick(0);
		check(32'(blk_out[0]), 32'h1);
		fab_u.tick(1);
		check(32'(blk_out[0]), 32'h0);
		fab_u.tick(1);
		check(32'(blk_out[0]), 32'h1);
		// clear 0 selected, then made active by inversion
		apb(1'b1, a_mc, 32'h19);
		fab_u.pins(32'h0, 2'h3, 2'h1);
		repeat (5) @(posedge ref_clk);
		check(32'(blk_out[0]), 32'h0);
		fab_u.pins(32'h1, 2'h3, 2'h0);
		fab_u.tick(1);
		check(32'(blk_out[0]), 32'h1);
		apb(1'b1, a_ctl, 32'h200);
		repeat (5) @(posedge ref_clk);
		check(32'(blk_out[0]), 32'h0);
		$display("test product terms done");
		// memory role, single clock
		apb(1'b1, a_ctl, 32'h1);
		fab_u.pins(32'h0, 2'h3, 2'h0);
		fab_u.op(1'b1, 13'h005, 16'ha5c3, 1'b0, 13'h0, 0);
		mread(13'h005, 0, 16'ha5c3);
		check(32'(col_data), 32'ha5c3);
		check(32'(col_oe), 32'h1);
		check(32'(local_out), 32'h0000_03c3);
		fab_u.op(1'b1, 13'h005, 16'h1234, 1'b1, 13'h005, 0);
		check(32'(blk_out), 32'ha5c3);
		mread(13'h005, 0, 16'h1234);
		// clear 1 empties the read side, never the array
		fab_u.pins(32'h0, 2'h3, 2'h2);
		repeat (5) @(posedge ref_clk);
		check(32'(blk_out), 32'h0);
		fab_u.pins(32'h0, 2'h3, 2'h0);
		mread(13'h005, 0, 16'h1234);
		// output register adds one output event of delay
		apb(1'b1, a_ctl, 32'h11);
		fab_u.op(1'b1, 13'h006, 16'h0f0f, 1'b0, 13'h0, 0);
		mread(13'h006, 0, 16'h1234);
		fab_u.tick(0);
		check(32'(blk_out), 32'h0f0f);
		// read/write clocks: reads wait for clock 1
		apb(1'b1, a_ctl, 32'h21);
		fab_u.op(1'b1, 13'h007, 16'hbeef, 1'b0, 13'h0, 0);
		mread(13'h007, 0, 16'h0f0f);
		mread(13'h007, 1, 16'hbeef);
		// input/output clocks: output register only on clock 1
		apb(1'b1, a_ctl, 32'h51);
		fab_u.op(1'b1, 13'h008, 16'h4242, 1'b0, 13'h0, 0);
		fab_u.op(1'b0, 13'h0, 16'h0, 1'b1, 13'h008, 0);
		fab_u.tick(1);
		check(32'(blk_out), 32'h4242);
		fab_u.op(1'b1, 13'h009, 16'h5555, 1'b0, 13'h0, 0);
		mread(13'h009, 0, 16'h4242);
		fab_u.tick(1);
		check(32'(blk_out), 32'h5555);
		$display("test memory modes done");
		// every aspect ratio: all-ones write reads back word width only
		for (int a = 0; a < 5; a++) begin
			apb(1'b1, a_ctl, 32'(1 + 2 * a));
			fab_u.op(1'b1, 13'h003, 16'hffff, 1'b0, 13'h0, 0);
			mread(13'h003, 0, 16'((17'h1 << (16 >> a)) - 17'h1));
		end
		// page decode: only page 2 drives the column line
		apb(1'b1, a_ctl, 32'h2801);
		fab_u.op(1'b0, 13'h0, 16'h0, 1'b1, {2'h2, 11'h003}, 0);
		check(32'(col_oe), 32'h1);
		fab_u.op(1'b0, 13'h0, 16'h0, 1'b1, {2'h1, 11'h003}, 0);
		check(32'(col_oe), 32'h0);
		$display("test aspect and paging done");
		complete_run();
	end
endmodule
